// [tb/nv_access_ctrl_checker.sv]
// Port-level checker for the data array controller and its register bus.
// Assumes it is bound to nv_access_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module nv_access_checker
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        irq
);
    // Addresses are kept so that the response code can be judged when it appears.
    logic [7:0] rd_addr_q;
    logic [7:0] wr_addr_q;

    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_q <= s_axi_araddr;
        if (s_axi_awvalid && s_axi_awready)
            wr_addr_q <= s_axi_awaddr;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ar_cause_a:
        assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("read answer without a taken address");
    ar_block_a:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    b_cause_a:
        assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("write answer before address and data held");
    b_block_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    byte_lane_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read data wider than one byte");
    rresp_map_a:
        assert property (s_axi_rvalid |-> s_axi_rresp == (rd_addr_q[7:2] > 6 ? 2'h2 : 2'h0))
        else $error("read response code wrong");
    bresp_map_a:
        assert property (s_axi_bvalid |-> s_axi_bresp == (wr_addr_q[7:2] > 6 ? 2'h2 : 2'h0))
        else $error("write response code wrong");
    rst_quiet_a:
        assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq)
        else $error("outputs active after reset");
    irq_fall_a:
        assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("interrupt dropped without a register write");

    cov_write: cover property ($rose(s_axi_bvalid));
    cov_read: cover property ($rose(s_axi_rvalid));
    cov_irq: cover property ($rose(irq));
endmodule // nv_access_checker

bind nv_access_ctrl nv_access_checker checker_i
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq
);

`default_nettype wire

// [tb/test_data_eeprom_access_control.sv]
// Self-checking bench for the data array controller, driven over its register bus.
// Assumes the package, header and design modules are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_regs.svh"

module test_data_eeprom_access_control;
    localparam logic [7:0] AD = `NV_ADDR_LOW_OFFS;
    localparam logic [7:0] DT = `NV_DATA_LOW_OFFS;
    localparam logic [7:0] CT = `NV_CONTROL_OFFS;
    localparam logic [7:0] KY = `NV_UNLOCK_KEY_OFFS;
    localparam logic [7:0] ST = `NV_IRQ_STATUS_OFFS;
    localparam logic [7:0] CL = `NV_IRQ_CLEAR_OFFS;
    localparam logic [7:0] EN = `NV_IRQ_ENABLE_OFFS;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    // Both response readies stay high, which keeps every answer to one cycle.
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        data_protect_fuse = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rd;
    int          bad_count = 0;
    int          checks_done = 0;

    always #10 aclk = ~aclk;

    nv_access_ctrl #(.POWERUP_CYCLES(16), .WRITE_CYCLES(8)) nv_access_ctrl_i
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .data_protect_fuse, .irq
    );

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic guard(inout int n);
        n++;
        if (n > 60)
        begin
            bad_count++;
            final_report;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            guard(n);
        end
        while (s_axi_bvalid !== 1'b1);
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            guard(n);
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        rdr(a);
        chk(nm, e, rd);
    endtask

    // Loads address and data, unlocks and triggers; write allow must already be set.
    // Keys and trigger go back to back, with no other access in between.
    task automatic go(input logic [7:0] a, input logic [7:0] d);
        wr(AD, a);
        wr(DT, d);
        wr(KY, `NV_KEY_FIRST);
        wr(KY, `NV_KEY_SECOND);
        wr(CT, 8'h06);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do
        begin
            rdr(CT);
            guard(n);
        end
        while (rd[1] !== 1'b0);
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        wr(CT, 8'h04);
        wr(KY, `NV_KEY_FIRST);
        wr(KY, `NV_KEY_SECOND);
        wr(CT, 8'h06);
        rc("ctl_powerup", CT, 8'h04);
        $display("test power_up done");
        repeat (16) @(posedge aclk);
        go(8'h3c, 8'ha5);
        rc("ctl_busy", CT, 8'h06);
        wait_done;
        chk("ctl_end", 8'h14, rd);
        rc("status_set", ST, 8'h01);
        $display("test write done");
        wr(EN, 8'h01);
        @(posedge aclk);
        chk("irq_on", 1, irq);
        wr(EN, 8'h00);
        @(posedge aclk);
        chk("irq_masked", 0, irq);
        rc("status_kept", ST, 8'h01);
        wr(ST, 8'h00);
        rc("status_ro", ST, 8'h01);
        wr(EN, 8'h01);
        wr(CL, 8'h01);
        @(posedge aclk);
        chk("irq_off", 0, irq);
        rc("status_clr", ST, 8'h00);
        $display("test interrupt done");
        data_protect_fuse <= 1'b1;
        wr(DT, 8'h00);
        wr(CT, 8'h01);
        rc("rd_fuse", DT, 8'ha5);
        wr(AD, 8'h10);
        rc("rd_hold", DT, 8'ha5);
        $display("test read done");
        wr(CT, 8'h04);
        wr(AD, 8'h3c);
        wr(DT, 8'h5a);
        wr(CT, 8'h06);
        rc("no_keys", CT, 8'h04);
        wr(KY, `NV_KEY_SECOND);
        wr(KY, `NV_KEY_FIRST);
        wr(CT, 8'h06);
        rc("key_order", CT, 8'h04);
        wr(KY, `NV_KEY_FIRST);
        wr(AD, 8'h3c);
        wr(KY, `NV_KEY_SECOND);
        wr(CT, 8'h06);
        rc("key_break", CT, 8'h04);
        wr(CT, 8'h00);
        wr(KY, `NV_KEY_FIRST);
        wr(KY, `NV_KEY_SECOND);
        wr(CT, 8'h02);
        rc("no_allow", CT, 8'h00);
        wr(CT, 8'h01);
        rc("array_same", DT, 8'ha5);
        $display("test refusal done");
        wr(CT, 8'h04);
        go(8'h3c, 8'h69);
        wr(CT, 8'h02);
        wait_done;
        chk("ctl_noallow", 8'h10, rd);
        wr(CT, 8'h01);
        rc("rd_new", DT, 8'h69);
        wr(DT, 8'h33);
        wr(CT, 8'hc5);
        rc("rd_sel", DT, 8'h33);
        wr(KY, `NV_KEY_FIRST);
        wr(KY, `NV_KEY_SECOND);
        wr(CT, 8'hc6);
        rc("wr_sel", CT, 8'hc4);
        wr(CT, 8'h01);
        rc("arr_sel", DT, 8'h69);
        rdr(8'h1c);
        chk("rresp_bad", 2'h2, rs);
        chk("rdata_bad", 0, rd);
        wr(8'h20, 0, 2'h2);
        $display("test abort_map done");
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctl_reset", CT, 8'h00);
        rc("en_reset", EN, 8'h00);
        chk("irq_reset", 0, irq);
        $display("test reset done");
        final_report;
    end
endmodule // test_data_eeprom_access_control

`default_nettype wire

// [verilog/nv_access_ctrl.sv]
// Data array access controller with an AXI4-Lite register slave.
// Assumes a single master; aclk at 50 MHz; data_protect_fuse is a static level.
//
// Overview of operation
// (RQ1) Each access moves one byte at the address in the low address register.
// (RQ2) Software reads by loading address, clearing space selects, then setting read.
// (RQ3) The read byte lands in the data register by the next cycle.
// (RQ4) The data register holds a read result until another read or write.
// (RQ5) Reads work regardless of the data protect fuse.
// (RQ6) Software loads address and data before starting a write.
// (RQ7) A write starts only after keys 55h then AAh, then the trigger.
// (RQ8) Software keeps interrupts off during the unlock sequence.
// (RQ9) The write trigger cannot be set while write allow is clear.
// (RQ10) Write allow changes only by software or reset, never by hardware.
// (RQ11) Clearing write allow mid-cycle does not abort the write.
// (RQ12) Software keeps write allow clear except while updating.
// (RQ13) At write end the trigger clears and the completion flag sets.
// (RQ14) The completion flag stays set until software clears it.
// (RQ15) Reset clears write allow; writes are blocked during the power-up time.
// (RQ16) Write duration is a parameter; the trigger reads one while busy.
// (RQ17) A wrong key or out-of-order trigger restarts the unlock sequence.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_regs.svh"

module nv_access_ctrl
#(
    parameter int POWERUP_CYCLES = `NV_POWERUP_CYCLES,
    parameter int WRITE_CYCLES   = `NV_WRITE_CYCLES
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        data_protect_fuse,
    output logic             irq
);

    // All controller state sits in one struct: one process computes it, one registers it.
    typedef struct packed {
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [7:0]  addr;
        logic [7:0]  data;
        logic        prog_sel;
        logic        cfg_sel;
        logic        allow;
        logic        writing;
        logic        complete;
        logic        irq_en;
        logic [31:0] pwr_cnt;
    } state_t;

    state_t s_q;
    state_t s_d;

    nv_access_pkg::reg_write_t   rw;
    nv_access_pkg::byte_write_t  arr_wr;
    logic [7:0] arr_rd;
    logic       arr_done;
    logic       arr_busy;
    logic       key_armed;
    logic       key_wr;
    logic       ctrl_wr;
    logic       trig_req;
    logic       start_wr;
    logic       read_req;
    logic       pwr_ready;
    logic [7:0] ctrl_view;

    // The counter stops at its end value, so writes stay possible until the next reset.
    assign pwr_ready = (s_q.pwr_cnt == 32'(POWERUP_CYCLES));

    // Address and data are parked separately, so either may arrive first; the write acts
    // in the one cycle in which both are parked and its answer is not yet out.
    always_comb
    begin
        rw.valid = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        rw.addr  = s_q.aw_addr;
        rw.data  = s_q.w_data;
        rw.strb  = s_q.w_strb;
    end

    assign key_wr   = rw.valid && rw.addr == `NV_UNLOCK_KEY_OFFS && rw.strb[0];
    assign ctrl_wr  = rw.valid && rw.addr == `NV_CONTROL_OFFS && rw.strb[0];
    // Either busy indication blocks a new trigger; the trigger bit outlasts the array by one cycle.
    assign trig_req = ctrl_wr && rw.data[`NV_CTRL_WRITE_BIT] && !s_q.writing && !arr_busy;
    // Allow is taken from the stored bit; a set of allow in the same write is not enough.
    assign start_wr = trig_req && key_armed && s_q.allow && pwr_ready
                      && !s_q.prog_sel && !s_q.cfg_sel; // see (RQ7) see (RQ9) see (RQ15)
    // The fuse is not consulted: it only limits external programmer access.
    assign read_req = ctrl_wr && rw.data[`NV_CTRL_READ_BIT]
                      && !rw.data[`NV_CTRL_PROG_BIT] && !rw.data[`NV_CTRL_CFG_BIT]; // see (RQ5)

    assign arr_wr.valid = start_wr;
    assign arr_wr.addr  = s_q.addr; // see (RQ1)
    assign arr_wr.data  = s_q.data;

    // Any completed bus write other than a key counts against a half-entered key pair.
    nv_unlock_tracker u_unlock
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .key_write   (key_wr),
        .key_value   (rw.data[7:0]),
        .other_write (rw.valid && !key_wr),
        .consume     (trig_req), // see (RQ17)
        .armed       (key_armed)
    );

    nv_byte_array #(.WRITE_CYCLES(WRITE_CYCLES)) u_array
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .rd_addr (s_q.addr),
        .rd_data (arr_rd),
        .wr      (arr_wr),
        .busy    (arr_busy),
        .done    (arr_done)
    );

    always_comb
    begin
        // Unused control bits read as zero.
        ctrl_view = 8'h00;
        ctrl_view[`NV_CTRL_PROG_BIT]  = s_q.prog_sel;
        ctrl_view[`NV_CTRL_CFG_BIT]   = s_q.cfg_sel;
        ctrl_view[`NV_CTRL_ALLOW_BIT] = s_q.allow;
        ctrl_view[`NV_CTRL_WRITE_BIT] = s_q.writing; // see (RQ16)
        ctrl_view[`NV_CTRL_COMPL_BIT] = s_q.complete;
    end

    always_comb
    begin
        s_d = s_q;
        if (!pwr_ready)
        begin
            s_d.pwr_cnt = s_q.pwr_cnt + 32'h0000_0001;
        end

        if (s_axi_awvalid && !s_q.aw_held)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !s_q.w_held)
        begin
            s_d.w_held = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end

        if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid  = 1'b0;
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
        end

        if (rw.valid)
        begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = 2'b00;
            case (rw.addr)
                `NV_ADDR_LOW_OFFS:
                begin
                    if (rw.strb[0]) s_d.addr = rw.data[7:0];
                end
                `NV_DATA_LOW_OFFS:
                begin
                    if (rw.strb[0]) s_d.data = rw.data[7:0]; // see (RQ4)
                end
                `NV_CONTROL_OFFS:
                begin
                    if (rw.strb[0])
                    begin
                        s_d.prog_sel = rw.data[`NV_CTRL_PROG_BIT];
                        s_d.cfg_sel  = rw.data[`NV_CTRL_CFG_BIT];
                        s_d.allow    = rw.data[`NV_CTRL_ALLOW_BIT]; // see (RQ10) see (RQ11)
                        if (!rw.data[`NV_CTRL_COMPL_BIT])
                        begin
                            s_d.complete = 1'b0;
                        end
                    end
                end
                `NV_IRQ_CLEAR_OFFS:
                begin
                    if (rw.strb[0] && rw.data[0]) s_d.complete = 1'b0;
                end
                `NV_IRQ_ENABLE_OFFS:
                begin
                    if (rw.strb[0]) s_d.irq_en = rw.data[0];
                end
                `NV_UNLOCK_KEY_OFFS:
                begin
                    // Key values go to the tracker; nothing is stored here.
                    s_d.bresp = 2'b00;
                end
                `NV_IRQ_STATUS_OFFS:
                begin
                    // Status is read-only; the write is answered and ignored.
                    s_d.bresp = 2'b00;
                end
                default:
                begin
                    s_d.bresp = 2'b10;
                end
            endcase
        end

        if (read_req)
        begin
            s_d.data = arr_rd; // see (RQ3) see (RQ4)
        end

        // The trigger bit doubles as the busy flag for the whole write time.
        if (start_wr)
        begin
            s_d.writing = 1'b1; // see (RQ16)
        end
        // Completion is applied last so it wins over a clear in the same cycle.
        if (arr_done)
        begin
            s_d.writing  = 1'b0; // see (RQ13)
            s_d.complete = 1'b1; // see (RQ14)
        end

        // The read answer is built from the state before this edge and stands until taken.
        if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = 2'b00;
            s_d.rdata  = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                `NV_ADDR_LOW_OFFS:   s_d.rdata[7:0] = s_q.addr;
                `NV_DATA_LOW_OFFS:   s_d.rdata[7:0] = s_q.data;
                `NV_CONTROL_OFFS:    s_d.rdata[7:0] = ctrl_view;
                `NV_UNLOCK_KEY_OFFS: s_d.rdata = 32'h0000_0000;
                `NV_IRQ_STATUS_OFFS: s_d.rdata[0] = s_q.complete;
                `NV_IRQ_CLEAR_OFFS:  s_d.rdata = 32'h0000_0000;
                `NV_IRQ_ENABLE_OFFS: s_d.rdata[0] = s_q.irq_en;
                default:             s_d.rresp = 2'b10;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q          <= '0;
            // Write allow starts clear so that no write can follow a power loss by accident.
            s_q.allow    <= 1'(`NV_CTRL_RESET >> `NV_CTRL_ALLOW_BIT); // see (RQ15)
            s_q.irq_en   <= `NV_IRQ_EN_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = !s_q.aw_held;
    assign s_axi_wready  = !s_q.w_held;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;
    assign irq           = s_q.complete && s_q.irq_en;

endmodule // nv_access_ctrl

`default_nettype wire

// [verilog/nv_access_pkg.sv]
// Types shared by the data array controller and its helpers.
// Assumes nothing of its surroundings.
`default_nettype none

package nv_access_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_FIRST_SEEN,
        KEY_ARMED
    } key_state_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [7:0] data;
    } byte_write_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_write_t;

endpackage

`default_nettype wire

// [verilog/nv_access_regs.svh]
// Register offsets, field positions, reset values and timing counts of the data array controller.
// Assumes a 50 MHz aclk; included by bare name.
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH

`define NV_ADDR_LOW_OFFS    8'h00
`define NV_DATA_LOW_OFFS    8'h04
`define NV_CONTROL_OFFS     8'h08
`define NV_UNLOCK_KEY_OFFS  8'h0C
`define NV_IRQ_STATUS_OFFS  8'h10
`define NV_IRQ_CLEAR_OFFS   8'h14
`define NV_IRQ_ENABLE_OFFS  8'h18

`define NV_CTRL_READ_BIT    0
`define NV_CTRL_WRITE_BIT   1
`define NV_CTRL_ALLOW_BIT   2
`define NV_CTRL_CFG_BIT     6
`define NV_CTRL_PROG_BIT    7
`define NV_CTRL_COMPL_BIT   4

`define NV_KEY_FIRST        8'h55
`define NV_KEY_SECOND       8'hAA

`define NV_CTRL_RESET       8'h00
`define NV_IRQ_EN_RESET     1'b0

`define NV_CLK_MHZ          50
`define NV_POWERUP_MS       64
`define NV_POWERUP_CYCLES   (`NV_POWERUP_MS * 1000 * `NV_CLK_MHZ)
`define NV_WRITE_US         4000
`define NV_WRITE_CYCLES     (`NV_WRITE_US * `NV_CLK_MHZ)

`endif

// [verilog/nv_byte_array.sv]
// Byte-wide data array in flip-flops with a combinational read and a timed write cycle.
// Assumes the controller issues one write at a time and waits for done.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_regs.svh"

module nv_byte_array
#(
    parameter int WRITE_CYCLES = `NV_WRITE_CYCLES
)
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [7:0]                rd_addr,
    output logic [7:0]                     rd_data,
    input  wire nv_access_pkg::byte_write_t wr,
    output logic                           busy,
    output logic                           done
);

    typedef struct packed {
        logic [255:0][7:0] mem;
        logic              busy;
        logic              done;
        logic [31:0]       cnt;
        logic [7:0]        addr;
        logic [7:0]        data;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy && wr.valid)
        begin
            s_d.busy = 1'b1;
            s_d.cnt  = 32'h0000_0000;
            s_d.addr = wr.addr;
            s_d.data = wr.data;
        end
        else if (s_q.busy)
        begin
            // The array content only changes when the cycle ends, like a real cell.
            if (s_q.cnt == 32'(WRITE_CYCLES - 1))
            begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.mem[s_q.addr] = s_q.data;
            end
            else
            begin
                s_d.cnt = s_q.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q.busy <= 1'b0;
            s_q.done <= 1'b0;
            s_q.cnt  <= 32'h0000_0000;
            s_q.addr <= 8'h00;
            s_q.data <= 8'h00;
            s_q.mem  <= s_d.mem;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.mem[rd_addr]; // see (RQ1)
    assign busy    = s_q.busy;
    assign done    = s_q.done;

endmodule // nv_byte_array

`default_nettype wire

// [verilog/nv_unlock_tracker.sv]
// Unlock key sequence tracker: arms after the two keys arrive in order.
// Assumes key writes are one-cycle pulses from the register slave.
`timescale 1ns/1ps
`default_nettype none
`include "nv_access_regs.svh"

module nv_unlock_tracker
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       key_write,
    input  wire logic [7:0] key_value,
    input  wire logic       other_write,
    input  wire logic       consume,
    output logic            armed
);

    typedef struct packed {
        nv_access_pkg::key_state_t st;
    } state_t;

    state_t s_q;
    state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (consume)
        begin
            s_d.st = nv_access_pkg::KEY_IDLE;
        end
        else if (key_write)
        begin
            if (key_value == `NV_KEY_FIRST)
            begin
                s_d.st = nv_access_pkg::KEY_FIRST_SEEN;
            end
            else if (key_value == `NV_KEY_SECOND && s_q.st == nv_access_pkg::KEY_FIRST_SEEN)
            begin
                s_d.st = nv_access_pkg::KEY_ARMED; // see (RQ7)
            end
            else
            begin
                s_d.st = nv_access_pkg::KEY_IDLE; // see (RQ17)
            end
        end
        else if (other_write && s_q.st == nv_access_pkg::KEY_FIRST_SEEN)
        begin
            // Any other register write between the two keys breaks the sequence.
            s_d.st = nv_access_pkg::KEY_IDLE; // see (RQ17)
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q.st <= nv_access_pkg::KEY_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign armed = (s_q.st == nv_access_pkg::KEY_ARMED);

endmodule // nv_unlock_tracker

`default_nettype wire
